// *** ffp_partner.sv ***
`timescale 1ns/1ps
module ffp_partner
  import ffp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate state
  input wire logic gate_force_off,
  // Burst idle: no switching cycles, feedback below the low level
  input wire logic burst,
  // Events and supply
  output ffp_event_t evt,
  output ffp_supply_t supply
);
  logic [1:0] ph;
  logic [5:0] vdd;
  // Events keep coming while off, so restart must ignore them
  assign evt = '{ph == 2'h3 && !burst, ph == 2'h2 && !burst, ph == 2'h1 && !burst, !burst,
    burst};
  assign supply = '{vdd[5:1] == 5'h14, vdd[5:1] == 5'h1E};
  always_ff @(posedge clk) begin
    ph <= rst ? 2'h0 : ph + 2'h1;
    vdd <= (rst || !gate_force_off) ? 6'h00 : vdd + 6'h01;
  end
endmodule

// *** ffp_pkg.sv ***
package ffp_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int OVP_CYCLE_COUNT = 2;
  localparam int UVP_DEBOUNCE_CYCLES = 4;
  localparam int UVP_BLANK_MS = 45;
  localparam int UVP_BLANK_CYCLES = UVP_BLANK_MS * (CLK_HZ / 1000);
  localparam int SD_DEBOUNCE_US = 400;
  localparam int SD_DEBOUNCE_CYCLES = SD_DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int CS_SHORT_CYCLE_COUNT = 2;
  localparam int EXT_RESTART_CYCLES = 2;
  localparam int CNT_W = 4;
  localparam int TMR_W = 20;

  typedef enum {
    FFP_RUN,
    FFP_RESTART,
    FFP_EXT_RESTART
  } ffp_state_t;

  typedef struct packed {
    logic aux_ovp;
    logic aux_uvp;
    logic shutdown_low;
    logic cs_limit;
    logic cs_diode_short;
    logic cs_short;
  } ffp_comp_t;

  typedef struct packed {
    logic cycle_end;
    logic diode_end;
    logic cs_blank_end;
    logic fb_above_burst_high;
    logic fb_below_burst_low;
  } ffp_event_t;

  typedef struct packed {
    logic supply_hv_on;
    logic supply_turn_on;
  } ffp_supply_t;
endpackage

// *** ffp_protect.sv ***
`timescale 1ns/1ps
module ffp_protect
  import ffp_pkg::*;
#(
  parameter int OVP_COUNT = OVP_CYCLE_COUNT,
  parameter int UVP_COUNT = UVP_DEBOUNCE_CYCLES,
  parameter int CS_SHORT_COUNT = CS_SHORT_CYCLE_COUNT,
  parameter int BLANK_CYCLES = UVP_BLANK_CYCLES,
  parameter int SD_CYCLES = SD_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Comparators, events, supply levels
  input wire ffp_comp_t comp,
  input wire ffp_event_t evt,
  input wire ffp_supply_t supply,
  // Gate control
  output logic gate_force_off,
  output logic gate_pulse_end,
  // Status
  output logic aux_sense_overvoltage_fault,
  output logic aux_sense_undervoltage_fault,
  output logic shutdown_fault,
  output logic cs_fault,
  output logic in_restart,
  output logic in_ext_restart
);

  ffp_state_t state;
  ffp_state_t next_state;
  logic [CNT_W-1:0] ovp_cnt;
  logic [CNT_W-1:0] uvp_cnt;
  logic [CNT_W-1:0] css_cnt;
  logic [TMR_W-1:0] blank_tmr;
  logic [TMR_W-1:0] sd_tmr;
  logic [1:0] ext_cnt;
  logic diode_short_seen;
  logic sd_sample;
  logic hv_seen;

  wire running = (state == FFP_RUN);
  wire blank_done = (blank_tmr >= TMR_W'(BLANK_CYCLES));
  // Per gate cycle in normal load, every clock in burst idle
  wire sd_strobe = (evt.fb_above_burst_high & evt.cycle_end) | evt.fb_below_burst_low;
  wire sd_hit = sd_tmr >= TMR_W'(SD_CYCLES);
  wire ovp_trip = evt.cycle_end & comp.aux_ovp & (ovp_cnt >= CNT_W'(OVP_COUNT));
  wire uvp_trip = evt.diode_end & comp.aux_uvp & blank_done
    & (uvp_cnt >= CNT_W'(UVP_COUNT));
  wire css_trip = evt.cs_blank_end & comp.cs_short
    & (css_cnt >= CNT_W'(CS_SHORT_COUNT));
  wire dshort_trip = diode_short_seen & evt.cycle_end;
  wire ar_trip = ovp_trip | css_trip | dshort_trip | sd_hit;
  wire leave = (state != FFP_RUN) & (next_state == FFP_RUN);
  wire clear_all = leave | !running;

  // One step of a consecutive-cycle counter: a faulty cycle counts, a clean one clears
  function automatic logic [CNT_W-1:0] cycle_step(input logic strobe, input logic bad,
      input logic [CNT_W-1:0] cnt);
    if (!strobe) begin
      return cnt;
    end else if (bad) begin
      return cnt + 1'b1;
    end else begin
      return '0;
    end
  endfunction

  wire [CNT_W-1:0] next_ovp_cnt = cycle_step(evt.cycle_end, comp.aux_ovp, ovp_cnt);
  // Samples inside the startup blank count as clean, so blanking cannot pre-load a trip
  wire [CNT_W-1:0] next_uvp_cnt = cycle_step(evt.diode_end, comp.aux_uvp & blank_done,
    uvp_cnt);
  wire [CNT_W-1:0] next_css_cnt = cycle_step(evt.cs_blank_end, comp.cs_short, css_cnt);
  // Timer holds at the limit so a long low cannot wrap it back below the trip point
  wire [TMR_W-1:0] next_sd_tmr = !sd_sample ? '0 : (sd_hit ? sd_tmr : sd_tmr + 1'b1);

  always_comb begin
    next_state = state;
    case (state)
      FFP_RUN: begin
        if (uvp_trip) begin
          next_state = FFP_EXT_RESTART;
        end else if (ar_trip) begin
          next_state = FFP_RESTART;
        end
      end
      FFP_RESTART: begin
        if (hv_seen && supply.supply_turn_on) begin
          next_state = FFP_RUN;
        end
      end
      FFP_EXT_RESTART: begin
        if (ext_cnt == 2'(EXT_RESTART_CYCLES) && supply.supply_turn_on) begin
          next_state = FFP_RUN;
        end
      end
      default: next_state = FFP_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FFP_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Startup blank runs once from power-up; restart does not re-arm it
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_tmr <= '0;
    end else if (ce && !blank_done) begin
      blank_tmr <= blank_tmr + 1'b1;
    end
  end

  // Cycle counters; a clean cycle or leaving restart clears them
  always_ff @(posedge clk) begin
    if (rst || (ce && clear_all)) begin
      ovp_cnt <= '0;
      uvp_cnt <= '0;
      css_cnt <= '0;
    end else if (ce) begin
      ovp_cnt <= next_ovp_cnt;
      uvp_cnt <= next_uvp_cnt;
      css_cnt <= next_css_cnt;
    end
  end

  // Diode short latch keeps the gate off until the next cycle end moves to restart
  always_ff @(posedge clk) begin
    if (rst || (ce && clear_all)) begin
      diode_short_seen <= 1'b0;
    end else if (ce && comp.cs_diode_short) begin
      diode_short_seen <= 1'b1;
    end
  end

  // Shutdown sample and its debounce timer
  always_ff @(posedge clk) begin
    if (rst || (ce && clear_all)) begin
      sd_sample <= 1'b0;
      sd_tmr <= '0;
    end else if (ce) begin
      if (sd_strobe) begin
        sd_sample <= comp.shutdown_low;
      end
      sd_tmr <= next_sd_tmr;
    end
  end

  // Supply tracking in both restart modes; a high-voltage level wins over the clear
  always_ff @(posedge clk) begin
    if (rst || (ce && running)) begin
      hv_seen <= 1'b0;
    end else if (ce) begin
      if (supply.supply_hv_on) begin
        hv_seen <= 1'b1;
      end else if (supply.supply_turn_on && state == FFP_EXT_RESTART) begin
        hv_seen <= 1'b0;
      end
    end
  end

  // Extended restart counts supply charge cycles, saturating at its target
  always_ff @(posedge clk) begin
    if (rst || (ce && running)) begin
      ext_cnt <= '0;
    end else if (ce && state == FFP_EXT_RESTART && supply.supply_hv_on && !hv_seen
        && ext_cnt != 2'(EXT_RESTART_CYCLES)) begin
      ext_cnt <= ext_cnt + 1'b1;
    end
  end

  // Status flags follow the faults that caused the stop
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_sense_overvoltage_fault <= 1'b0;
      aux_sense_undervoltage_fault <= 1'b0;
      shutdown_fault <= 1'b0;
      cs_fault <= 1'b0;
    end else if (ce) begin
      if (leave) begin
        aux_sense_overvoltage_fault <= 1'b0;
        aux_sense_undervoltage_fault <= 1'b0;
        shutdown_fault <= 1'b0;
        cs_fault <= 1'b0;
      end else if (running) begin
        aux_sense_overvoltage_fault <= ovp_trip;
        aux_sense_undervoltage_fault <= uvp_trip;
        shutdown_fault <= sd_hit;
        cs_fault <= css_trip | dshort_trip;
      end
    end
  end

  // Pulse end is combinational so the limit acts inside the same cycle
  assign gate_pulse_end = comp.cs_limit | comp.cs_diode_short;
  assign gate_force_off = !running | diode_short_seen;
  assign in_restart = (state == FFP_RESTART);
  assign in_ext_restart = (state == FFP_EXT_RESTART);

endmodule

// *** ffp_protect_asserts.sv ***
`timescale 1ns/1ps
module ffp_protect_asserts
  import ffp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Observed
  input wire ffp_comp_t comp,
  input wire ffp_supply_t supply,
  input wire logic gate_force_off,
  input wire logic gate_pulse_end,
  input wire logic aux_sense_overvoltage_fault,
  input wire logic aux_sense_undervoltage_fault,
  input wire logic shutdown_fault,
  input wire logic cs_fault,
  input wire logic in_restart,
  input wire logic in_ext_restart
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire run = !in_restart && !in_ext_restart;
  property p_lim; gate_pulse_end == (comp.cs_limit || comp.cs_diode_short); endproperty
  a_lim: assert property (p_lim) else $error("pulse end wrong");
  property p_off; !run |-> gate_force_off; endproperty
  a_off: assert property (p_off) else $error("gate on in restart");
  property p_ov; $rose(aux_sense_overvoltage_fault) |-> in_restart; endproperty
  a_ov: assert property (p_ov) else $error("ovp without restart");
  property p_uv; $rose(aux_sense_undervoltage_fault) |-> in_ext_restart; endproperty
  a_uv: assert property (p_uv) else $error("uvp without ext restart");
  property p_sd; $rose(shutdown_fault) |-> in_restart; endproperty
  a_sd: assert property (p_sd) else $error("shutdown without restart");
  property p_ex; $fell(in_restart) |-> $past(supply.supply_turn_on); endproperty
  a_ex: assert property (p_ex) else $error("early restart exit");
  property p_clr; run |-> !(aux_sense_overvoltage_fault || shutdown_fault || cs_fault); endproperty
  a_clr: assert property (p_clr) else $error("flag kept in run");
  property p_ds; ce && run && comp.cs_diode_short |=> gate_force_off; endproperty
  a_ds: assert property (p_ds) else $error("diode short not off");
endmodule

// *** test_ffp_protect.sv ***
`timescale 1ns/1ps
module test_ffp_protect;
  import ffp_pkg::*;
  typedef struct packed {logic [5:0] c; logic [7:0] w; logic [6:0] e;} ffp_row_t;
  logic clk = 0;
  logic rst = 1;
  logic burst = 0;
  logic gate_force_off, gate_pulse_end, ovf, uvf, sdf, csf, inr, inx;
  ffp_comp_t comp = '0;
  ffp_event_t evt;
  ffp_supply_t supply;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  // Waits cover trip plus a full partner supply cycle before the next row
  ffp_row_t rows [11] = '{'{6'h20, 8'h0E, 7'h22}, '{6'h00, 8'h40, 7'h00},
    '{6'h01, 8'h0E, 7'h06}, '{6'h00, 8'h40, 7'h00}, '{6'h08, 8'h1E, 7'h0A},
    '{6'h00, 8'h40, 7'h00}, '{6'h02, 8'h08, 7'h46}, '{6'h00, 8'h40, 7'h00},
    '{6'h10, 8'h18, 7'h11}, '{6'h00, 8'h8C, 7'h00}, '{6'h04, 8'h0E, 7'h40}};
  ffp_protect #(.BLANK_CYCLES(50), .SD_CYCLES(20)) dut_u (.clk, .rst, .ce(1'b1), .comp, .evt,
    .supply, .gate_force_off, .gate_pulse_end, .aux_sense_overvoltage_fault(ovf),
    .aux_sense_undervoltage_fault(uvf), .shutdown_fault(sdf), .cs_fault(csf),
    .in_restart(inr), .in_ext_restart(inx));
  ffp_partner pm_u (.clk, .rst, .gate_force_off, .burst, .evt, .supply);
  always #50 clk = ~clk;
  task automatic check(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    repeat (60) @(negedge clk);
    foreach (rows[i]) begin
      comp = rows[i].c;
      repeat (rows[i].w) @(negedge clk);
      check({gate_pulse_end, ovf, uvf, sdf, csf, inr, inx}, rows[i].e);
    end
    comp = '0;
    rst = 1;
    repeat (10) @(negedge clk);
    rst = 0;
    comp = 6'h10;
    repeat (30) @(negedge clk);
    check({gate_pulse_end, ovf, uvf, sdf, csf, inr, inx}, 7'h00);
    repeat (50) @(negedge clk);
    check({gate_pulse_end, ovf, uvf, sdf, csf, inr, inx}, 7'h11);
    comp = '0;
    repeat (140) @(negedge clk);
    check({gate_pulse_end, ovf, uvf, sdf, csf, inr, inx}, 7'h00);
    // Burst idle samples shutdown every clock, so the trip comes sooner than per cycle
    burst = 1;
    comp = 6'h08;
    repeat (22) @(negedge clk);
    check({gate_pulse_end, ovf, uvf, sdf, csf, inr, inx}, 7'h0A);
    burst = 0;
    comp = '0;
    summarize();
  end
endmodule
bind ffp_protect ffp_protect_asserts chk_u (.clk, .rst, .ce, .comp, .supply, .gate_force_off,
  .gate_pulse_end, .aux_sense_overvoltage_fault, .aux_sense_undervoltage_fault,
  .shutdown_fault, .cs_fault, .in_restart, .in_ext_restart);
